// [logic/fdw_dual_watchdog.sv]
// Dual watchdog of the fieldbus slave controller with register port and safe outputs.
`timescale 1ns/1ns
module fdw_dual_watchdog #(
   parameter int unsigned OUT_W = 16
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire fdw_pkg::fdw_reg_req_t reg_req_i,
   output fdw_pkg::fdw_reg_rsp_t reg_rsp_o,
   input wire logic buffer_exchange_i,
   input wire logic local_access_i,
   input wire logic safe_operational_state_i,
   input wire logic [OUT_W-1:0] process_out_i,
   output logic [OUT_W-1:0] process_out_o,
   output logic buffer_expired_o,
   output logic local_expired_o,
   output logic outputs_safe_o
);
   initial begin
      if (OUT_W < 1 || OUT_W > fdw_pkg::DATA_W) $error("fdw_dual_watchdog: OUT_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [15:0] prescaler;
      logic [15:0] local_timeout;
      logic [15:0] buffer_timeout;
      logic [15:0] safe_value;
      logic [OUT_W-1:0] out_data;
      logic safe;
      fdw_pkg::fdw_reg_rsp_t rsp;
   } fdw_main_state_t;

   fdw_main_state_t st_reg;
   fdw_main_state_t st_next;

   logic tick;
   logic buf_exp;
   logic loc_exp;
   logic buf_en;
   logic loc_en;
   logic [15:0] status;

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tick and the two timers

   fdw_tick_gen #(
      .BASE_DIV(fdw_pkg::BASE_DIV)
   ) u_tick (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .prescaler_i(st_reg.prescaler),
      .tick_o(tick)
   );

   fdw_timer u_buffer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .kick_i(buffer_exchange_i),
      .timeout_i(st_reg.buffer_timeout),
      .expired_o(buf_exp),
      .enabled_o(buf_en)
   );

   fdw_timer u_local (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .kick_i(local_access_i),
      .timeout_i(st_reg.local_timeout),
      .expired_o(loc_exp),
      .enabled_o(loc_en)
   );

   always_comb begin
      status = 16'h0000;
      status[fdw_pkg::STAT_BUF_EXPIRED] = buf_exp;
      status[fdw_pkg::STAT_LOC_EXPIRED] = loc_exp;
      status[fdw_pkg::STAT_BUF_ENABLED] = buf_en;
      status[fdw_pkg::STAT_LOC_ENABLED] = loc_en;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register port and output stage

   always_comb begin
      st_next = st_reg;
      st_next.rsp = '0;
      if (reg_req_i.wr) begin
         st_next.rsp.ack = 1'b1;
         unique case (reg_req_i.addr)
            fdw_pkg::OFF_PRESCALER: st_next.prescaler = reg_req_i.wdata;
            fdw_pkg::OFF_LOCAL_TIMEOUT: st_next.local_timeout = reg_req_i.wdata;
            fdw_pkg::OFF_BUFFER_TIMEOUT: st_next.buffer_timeout = reg_req_i.wdata;
            fdw_pkg::OFF_SAFE_VALUE: st_next.safe_value = reg_req_i.wdata;
            fdw_pkg::OFF_STATUS: begin
            end
            default: st_next.rsp.err = 1'b1;
         endcase
      end else if (reg_req_i.rd) begin
         st_next.rsp.ack = 1'b1;
         unique case (reg_req_i.addr)
            fdw_pkg::OFF_PRESCALER: st_next.rsp.rdata = st_reg.prescaler;
            fdw_pkg::OFF_LOCAL_TIMEOUT: st_next.rsp.rdata = st_reg.local_timeout;
            fdw_pkg::OFF_BUFFER_TIMEOUT: st_next.rsp.rdata = st_reg.buffer_timeout;
            fdw_pkg::OFF_SAFE_VALUE: st_next.rsp.rdata = st_reg.safe_value;
            fdw_pkg::OFF_STATUS: st_next.rsp.rdata = status;
            default: st_next.rsp.err = 1'b1;
         endcase
      end
      // the slave state input is left alone
      st_next.safe = buf_exp || loc_exp;
      if (buf_exp || loc_exp) begin
         st_next.out_data = st_reg.safe_value[OUT_W-1:0];
      end else begin
         // outputs pass even in safe-operational state
         st_next.out_data = process_out_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_reg.prescaler <= fdw_pkg::RST_PRESCALER;
         st_reg.local_timeout <= fdw_pkg::RST_LOCAL_TIMEOUT;
         st_reg.buffer_timeout <= fdw_pkg::RST_BUFFER_TIMEOUT;
         st_reg.safe_value <= fdw_pkg::RST_SAFE_VALUE;
         st_reg.out_data <= '0;
         st_reg.safe <= 1'b0;
         st_reg.rsp <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rsp_o = st_reg.rsp;
   assign process_out_o = st_reg.out_data;
   assign buffer_expired_o = buf_exp;
   assign local_expired_o = loc_exp;
   assign outputs_safe_o = st_reg.safe;
endmodule : fdw_dual_watchdog

// [shared/fdw_pkg.sv]
// Package with register map, reset values and carrier types of the dual watchdog.
package fdw_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 16;
   localparam logic [11:0] OFF_PRESCALER = 12'h400;
   localparam logic [11:0] OFF_LOCAL_TIMEOUT = 12'h410;
   localparam logic [11:0] OFF_BUFFER_TIMEOUT = 12'h420;
   localparam logic [11:0] OFF_STATUS = 12'h430;
   localparam logic [11:0] OFF_SAFE_VALUE = 12'h440;
   localparam logic [15:0] RST_PRESCALER = 16'h09c2;
   localparam logic [15:0] RST_LOCAL_TIMEOUT = 16'h03e8;
   localparam logic [15:0] RST_BUFFER_TIMEOUT = 16'h03e8;
   localparam logic [15:0] RST_SAFE_VALUE = 16'h0000;
   localparam int unsigned PRESCALE_EXTRA = 2;
   localparam int unsigned BASE_CLK_MHZ = 25;
   localparam int unsigned SYS_CLK_MHZ = 100;
   localparam int unsigned BASE_DIV = SYS_CLK_MHZ / BASE_CLK_MHZ;
   localparam int unsigned STAT_BUF_EXPIRED = 0;
   localparam int unsigned STAT_LOC_EXPIRED = 1;
   localparam int unsigned STAT_BUF_ENABLED = 2;
   localparam int unsigned STAT_LOC_ENABLED = 3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } fdw_reg_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [DATA_W-1:0] rdata;
   } fdw_reg_rsp_t;
endpackage : fdw_pkg

// [logic/fdw_tick_gen.sv]
// Shared watchdog tick generator: base clock divider and prescaler.
`timescale 1ns/1ns
module fdw_tick_gen #(
   parameter int unsigned BASE_DIV = fdw_pkg::BASE_DIV
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [15:0] prescaler_i,
   output logic tick_o
);
   initial begin
      if (BASE_DIV < 1 || BASE_DIV > 255) $error("fdw_tick_gen: BASE_DIV out of range");
   end

   typedef struct packed {
      logic [7:0] div;
      logic [16:0] pre;
      logic tick;
   } fdw_tick_state_t;

   fdw_tick_state_t st_reg;
   fdw_tick_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.div == 8'(BASE_DIV - 1)) begin
         st_next.div = 8'h00;
         if (st_reg.pre >= 17'({1'b0, prescaler_i}) + 17'(fdw_pkg::PRESCALE_EXTRA - 1)) begin
            st_next.pre = 17'h00000;
            st_next.tick = 1'b1;
         end else begin
            st_next.pre = st_reg.pre + 17'h00001;
         end
      end else begin
         st_next.div = st_reg.div + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_o = st_reg.tick;
endmodule : fdw_tick_gen

// [logic/fdw_timer.sv]
// One watchdog timer: counts shared ticks and flags expiry until restarted or disabled by a zero timeout.
`timescale 1ns/1ns
module fdw_timer (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic kick_i,
   input wire logic [15:0] timeout_i,
   output logic expired_o,
   output logic enabled_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic expired;
   } fdw_timer_state_t;

   fdw_timer_state_t st_reg;
   fdw_timer_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (timeout_i == 16'h0000) begin
         st_next.cnt = 16'h0000;
         st_next.expired = 1'b0;
      end else if (kick_i) begin
         st_next.cnt = 16'h0000;
         st_next.expired = 1'b0;
      end else if (tick_i && !st_reg.expired) begin
         if (st_reg.cnt + 16'h0001 >= timeout_i) begin
            st_next.expired = 1'b1;
            st_next.cnt = 16'h0000;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign expired_o = st_reg.expired;
   assign enabled_o = (timeout_i != 16'h0000);
endmodule : fdw_timer

// [verification/fdw_dual_watchdog_properties.sv]
// Checker for the register port and both watchdogs of the dual watchdog.
`timescale 1ns/1ns
module fdw_dual_watchdog_chk #(
   parameter int unsigned OUT_W = 16
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire fdw_pkg::fdw_reg_req_t reg_req_i,
   input wire fdw_pkg::fdw_reg_rsp_t reg_rsp_o,
   input wire logic buffer_exchange_i,
   input wire logic local_access_i,
   input wire logic [OUT_W-1:0] process_out_i,
   input wire logic [OUT_W-1:0] process_out_o,
   input wire logic buffer_expired_o,
   input wire logic local_expired_o,
   input wire logic outputs_safe_o
);
   logic req;
   logic any_exp;
   assign req = reg_req_i.wr | reg_req_i.rd;
   assign any_exp = buffer_expired_o | local_expired_o;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////
   AST_ACK_NEXT: assert property (req |=> reg_rsp_o.ack)
      else $error("request not answered");
   AST_ACK_ONLY: assert property (!req |=> !reg_rsp_o.ack)
      else $error("answer without request");
   // Nothing outside the 0x4xx page is mapped, so a read there must be refused.
   AST_UNMAPPED: assert property (reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr[11:8] != 4'h4
      |=> reg_rsp_o.err && reg_rsp_o.rdata == 16'h0000) else $error("unmapped read accepted");
   AST_BUF_KICK: assert property (buffer_exchange_i |=> !buffer_expired_o)
      else $error("buffer watchdog not restarted");
   AST_LOC_KICK: assert property (local_access_i |=> !local_expired_o)
      else $error("local watchdog not restarted");
   AST_BUF_HOLD: assert property (buffer_expired_o && !buffer_exchange_i && !reg_req_i.wr |=> buffer_expired_o)
      else $error("buffer expiry dropped without exchange");
   AST_SAFE: assert property (any_exp |=> outputs_safe_o)
      else $error("safe value not driven");
   AST_PASS: assert property (!any_exp |=> !outputs_safe_o && process_out_o == $past(process_out_i))
      else $error("outputs not passed through");
   cover property ($rose(buffer_expired_o));
   cover property ($rose(local_expired_o));
   cover property (reg_rsp_o.err);
endmodule : fdw_dual_watchdog_chk
bind fdw_dual_watchdog fdw_dual_watchdog_chk #(.OUT_W(OUT_W)) i_chk (.mclk_i, .rst_i, .reg_req_i, .reg_rsp_o,
   .buffer_exchange_i, .local_access_i, .process_out_i, .process_out_o, .buffer_expired_o, .local_expired_o,
   .outputs_safe_o);

// [verification/fdw_master_model.sv]
// Far-side model: network exchange and local processor access strobes.
`timescale 1ns/1ns
module fdw_master_model (
   input wire logic mclk_i,
   output logic buffer_exchange_o,
   output logic local_access_o
);
   initial begin
      buffer_exchange_o = 1'b0;
      local_access_o = 1'b0;
   end
   // one-cycle traffic strobe; the caller sets the pace, prompt or slow.
   task automatic pulse(input logic net);
      @(posedge mclk_i);
      if (net) buffer_exchange_o <= 1'b1;
      else local_access_o <= 1'b1;
      @(posedge mclk_i);
      buffer_exchange_o <= 1'b0;
      local_access_o <= 1'b0;
   endtask : pulse
endmodule : fdw_master_model

// [verification/test_fdw_dual_watchdog.sv]
// Self-checking testbench of the dual watchdog.
`timescale 1ns/1ns
module test_fdw_dual_watchdog;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   fdw_pkg::fdw_reg_req_t req = '0;
   fdw_pkg::fdw_reg_rsp_t rsp;
   logic bx;
   logic la;
   logic [15:0] pin = 16'h1234;
   logic sop = 1'b0;
   logic [15:0] pout;
   logic bexp;
   logic lexp;
   logic osafe;
   logic [15:0] rdat;
   int fail_count = 0;
   int samples_checked = 0;
   always #5 mclk_i = ~mclk_i;
   fdw_master_model i_far (.mclk_i, .buffer_exchange_o(bx), .local_access_o(la));
   fdw_dual_watchdog i_dut (.mclk_i, .rst_i, .reg_req_i(req), .reg_rsp_o(rsp), .buffer_exchange_i(bx),
      .local_access_i(la), .safe_operational_state_i(sop), .process_out_i(pin), .process_out_o(pout),
      .buffer_expired_o(bexp), .local_expired_o(lexp), .outputs_safe_o(osafe));
   ////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : wt
   // The answer stands for one cycle only, so it is sampled just after the taking edge.
   task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge mclk_i);
      req <= '0;
      #1;
      check("ack", rsp.ack, 16'h0001);
      rdat = rsp.rdata;
   endtask : acc
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////
   task automatic t_defaults;
      // nothing written yet, reset values remain
      acc(1'b0, 12'h400, 16'h0000);
      check("prescaler", rdat, 16'h09c2);
      acc(1'b0, 12'h410, 16'h0000);
      check("local_to", rdat, 16'h03e8);
      acc(1'b0, 12'h420, 16'h0000);
      check("buffer_to", rdat, 16'h03e8);
      acc(1'b0, 12'h7f0, 16'h0000);
      check("unmapped", {rsp.err, rdat[14:0]}, 16'h8000);
      acc(1'b1, 12'h430, 16'hffff);
      check("status_wr_err", rsp.err, 16'h0000);
      acc(1'b1, 12'h7f0, 16'h1234);
      check("unmapped_wr_err", rsp.err, 16'h0001);
      $display("defaults done");
   endtask : t_defaults
   task automatic t_buffer;
      acc(1'b1, 12'h420, 16'hffff);
      acc(1'b0, 12'h420, 16'h0000);
      check("buffer_max", rdat, 16'hffff);
      acc(1'b1, 12'h400, 16'h0000);
      acc(1'b1, 12'h420, 16'h0003);
      acc(1'b1, 12'h440, 16'h5a5a);
      i_far.pulse(1'b1);
      wt(14);
      check("early", bexp, 16'h0000);
      wt(12);
      check("expired", bexp, 16'h0001);
      check("safe_out", pout, 16'h5a5a);
      check("safe_flag", osafe, 16'h0001);
      wt(40);
      acc(1'b0, 12'h430, 16'h0000);
      check("status", rdat[0], 16'h0001);
      i_far.pulse(1'b1);
      #1;
      check("cleared", bexp, 16'h0000);
      wt(2);
      check("resumed", pout, 16'h1234);
      repeat (6) begin
         wt(10);
         check("kept", bexp, 16'h0000);
         i_far.pulse(1'b1);
      end
      $display("buffer done");
   endtask : t_buffer
   task automatic t_local;
      acc(1'b1, 12'h400, 16'hffff);
      acc(1'b0, 12'h400, 16'h0000);
      check("pre_max", rdat, 16'hffff);
      acc(1'b1, 12'h400, 16'h0001);
      acc(1'b1, 12'h420, 16'h0000);
      acc(1'b1, 12'h410, 16'h0002);
      i_far.pulse(1'b0);
      wt(10);
      check("loc_early", lexp, 16'h0000);
      wt(16);
      check("loc_exp", lexp, 16'h0001);
      acc(1'b0, 12'h430, 16'h0000);
      check("enables", rdat[3:0], 16'h000a);
      i_far.pulse(1'b0);
      pin <= 16'h00ff;
      sop <= 1'b1;
      wt(3);
      check("no_buf", bexp, 16'h0000);
      check("switch", pout, 16'h00ff);
      $display("local done");
   endtask : t_local
   initial begin
      wt(16);
      rst_i <= 1'b0;
      t_defaults();
      t_buffer();
      t_local();
      finish_test();
   end
   initial begin
      #50000;
      fail_count++;
      finish_test();
   end
endmodule : test_fdw_dual_watchdog
